/* File: pkg/mdbp_pkg.sv */
// Package for the doorbell pending block: offsets, fields, reset values.
// Assumes a 32-bit Avalon-MM slave with word addressing in byte units.
package mdbp_pkg;
   // Number of doorbell channels
   localparam int MDBP_CHANNELS = 4;
   // Register byte offsets
   localparam logic [7:0] MDBP_OFS_STATUS = 8'h00; // Pending flags, w1c
   localparam logic [7:0] MDBP_OFS_CONTROL = 8'h04; // Enables, request view
   localparam logic [7:0] MDBP_OFS_EVT_STATUS = 8'h08; // Sticky events, RO
   localparam logic [7:0] MDBP_OFS_EVT_CLEAR = 8'h0c; // Write-only clear
   localparam logic [7:0] MDBP_OFS_EVT_ENABLE = 8'h10; // Event enables
   // Field positions
   localparam int MDBP_PEND_LSB = 28; // Pending flags bits 31..28
   localparam int MDBP_REQ_LSB = 16; // Request bits 19..16
   localparam int MDBP_IEN_LSB = 28; // Interrupt enables bits 31..28
   // Reset values
   localparam logic [3:0] MDBP_PEND_RST = 4'h0;
   localparam logic [3:0] MDBP_IEN_RST = 4'h0;
   localparam logic [3:0] MDBP_EVT_RST = 4'h0;
   // Answer for an unmapped read
   localparam logic [31:0] MDBP_UNMAPPED_DATA = 32'h0000_0000;
   // Bus request carrier
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } mdbp_bus_req_t;
   // Slave state
   typedef enum logic [0:0] {MDBP_IDLE, MDBP_DONE} mdbp_state_t;
endpackage

/* File: src/mdbp_edge_sync.sv */
// Two-stage synchroniser with rising-edge pulse for one request line.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
module mdbp_edge_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic async_in,
   output logic level,
   output logic rise
);
   logic stage1; // Metastability catcher, read only by stage2
   logic stage2; // Safe level
   logic stage3; // Previous safe level, for edge detection

   // Shift chain; edge taken only from safe stages
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign level = stage2;
   assign rise = stage2 & ~stage3;
endmodule
`default_nettype wire

/* File: src/mdbp_doorbell.sv */
// Receiving side of a four-channel doorbell with Avalon-MM registers.
// Assumes remote request bits arrive asynchronously and the remote side
// waits for its request bit to read zero before raising it again.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module mdbp_doorbell
   import mdbp_pkg::*;
#(
   parameter int CHANNELS = MDBP_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [CHANNELS-1:0] doorbell_request,
   output logic [CHANNELS-1:0] doorbell_request_clear,
   output logic [CHANNELS-1:0] general_doorbell,
   output logic doorbell_irq,
   output logic event_irq
);
   mdbp_bus_req_t req; // Bundled bus request
   mdbp_state_t state; // Slave handshake state
   mdbp_state_t next_state;
   logic [CHANNELS-1:0] doorbell_pending; // Pending flags
   logic [CHANNELS-1:0] doorbell_irq_enable; // Per-channel enables
   logic [CHANNELS-1:0] req_level; // Synchronised remote request
   logic [CHANNELS-1:0] req_rise; // Rising edge pulses
   logic [CHANNELS-1:0] evt_status; // Sticky block events
   logic [CHANNELS-1:0] evt_enable; // Event interrupt enables
   logic [31:0] next_readdata;

   assign req.read = avs_read;
   assign req.write = avs_write;
   assign req.address = avs_address;
   assign req.writedata = avs_writedata;
   assign req.byteenable = avs_byteenable;

   // One synchroniser per channel; the pin is foreign to clk
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_sync
         mdbp_edge_sync u_sync (
            .clk(clk),
            .rst_b(rst_b),
            .async_in(doorbell_request[g]),
            .level(req_level[g]),
            .rise(req_rise[g])
         );
      end
   endgenerate

   // Address decode
   wire sel_status = req.address == MDBP_OFS_STATUS;
   wire sel_control = req.address == MDBP_OFS_CONTROL;
   wire sel_evt_status = req.address == MDBP_OFS_EVT_STATUS;
   wire sel_evt_clear = req.address == MDBP_OFS_EVT_CLEAR;
   wire sel_evt_enable = req.address == MDBP_OFS_EVT_ENABLE;
   // The write takes effect only in the cycle waitrequest is low
   wire wr_go = req.write & (state == MDBP_DONE);
   wire rd_go = req.read & (state == MDBP_IDLE);
   // Top byte lane holds both the pending and enable fields
   wire lane3 = req.byteenable[3];
   wire [CHANNELS-1:0] wr_hi =
      req.writedata[MDBP_PEND_LSB +: CHANNELS];

   // Clear mask: only ones at positions whose flag is set count
   wire [CHANNELS-1:0] pend_clear =
      (wr_go & sel_status & lane3) ? (wr_hi & doorbell_pending)
                                   : {CHANNELS{1'b0}};

   // Next pending: set beats clear when both arrive together
   wire [CHANNELS-1:0] next_pending =
      req_rise | (doorbell_pending & ~pend_clear);

   // Event: a doorbell edge that hits an already pending flag is lost
   wire [CHANNELS-1:0] evt_overrun = req_rise & doorbell_pending &
                                     ~pend_clear;
   wire [CHANNELS-1:0] evt_clear_mask =
      (wr_go & sel_evt_clear & lane3) ? wr_hi : {CHANNELS{1'b0}};

   // Enable value after this edge. The merged outputs are built from it
   // so that an enable write moves the channel request in the same cycle
   // as the enable bit itself; using the old value would leave a cycle
   // in which pending and enable are both set but no request stands.
   wire [CHANNELS-1:0] next_irq_enable =
      (wr_go & sel_control & lane3) ? wr_hi : doorbell_irq_enable;

   // Pending flags; reset to not pending
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         doorbell_pending <= MDBP_PEND_RST;
      end else begin
         doorbell_pending <= next_pending;
      end
   end

   // Acceptance pulse back to the remote request bit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         doorbell_request_clear <= {CHANNELS{1'b0}};
      end else begin
         doorbell_request_clear <= pend_clear;
      end
   end

   // Control and event enable registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         doorbell_irq_enable <= MDBP_IEN_RST;
         evt_enable <= MDBP_EVT_RST;
      end else begin
         if (wr_go && sel_control && lane3) begin
            doorbell_irq_enable <= wr_hi;
         end
         if (wr_go && sel_evt_enable && lane3) begin
            evt_enable <= wr_hi;
         end
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         evt_status <= MDBP_EVT_RST;
      end else begin
         evt_status <= evt_overrun | (evt_status & ~evt_clear_mask);
      end
   end

   // Per-channel requests and doorbell_irq are registered from the next
   // flag and enable values, so they mirror the stored registers exactly,
   // with no extra cycle of latency; event_irq is registered from the
   // stored evt_status and evt_enable, so it lags them by one cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         general_doorbell <= {CHANNELS{1'b0}};
         doorbell_irq <= 1'b0;
         event_irq <= 1'b0;
      end else begin
         general_doorbell <= next_pending & next_irq_enable;
         doorbell_irq <= |(next_pending & next_irq_enable);
         event_irq <= |(evt_status & evt_enable);
      end
   end

   // Read mux; request view shows the synchronised remote level
   always_comb begin
      next_readdata = MDBP_UNMAPPED_DATA;
      if (sel_status) begin
         next_readdata[MDBP_PEND_LSB +: CHANNELS] = doorbell_pending;
      end else if (sel_control) begin
         next_readdata[MDBP_IEN_LSB +: CHANNELS] = doorbell_irq_enable;
         next_readdata[MDBP_REQ_LSB +: CHANNELS] = req_level;
      end else if (sel_evt_status) begin
         next_readdata[MDBP_PEND_LSB +: CHANNELS] = evt_status;
      end else if (sel_evt_enable) begin
         next_readdata[MDBP_PEND_LSB +: CHANNELS] = evt_enable;
      end
   end

   // Handshake: each access stalls one cycle, then completes
   always_comb begin
      next_state = MDBP_IDLE;
      case (state)
         MDBP_IDLE: begin
            if (req.read || req.write) begin
               next_state = MDBP_DONE;
            end
         end
         MDBP_DONE: begin
            next_state = MDBP_IDLE;
         end
         default: begin
            next_state = MDBP_IDLE;
         end
      endcase
   end

   // State and registered read data
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= MDBP_IDLE;
         avs_readdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         if (rd_go) begin
            avs_readdata <= next_readdata;
         end
      end
   end

   // Waitrequest low in the completion cycle and whenever no access is requested
   assign avs_waitrequest = (req.read || req.write) && (state != MDBP_DONE);

   // Checks. They watch the flags, outputs and read data that this
   // module drives; bus and remote stimulus are left to the bench.
   pend_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      req_rise[0] |=> doorbell_pending[0])
      else $error("edge did not set pending flag");

   pend_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (pend_clear[0] && !req_rise[0]) |=> !doorbell_pending[0])
      else $error("write one did not clear flag");

   no_spurious_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!doorbell_pending[1] && !req_rise[1]) |=> !doorbell_pending[1])
      else $error("flag set without edge");

   zero_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      (doorbell_pending[2] && !pend_clear[2]) |=> doorbell_pending[2])
      else $error("flag lost without clear");

   chan_req_a: assert property (@(posedge clk) disable iff (!rst_b)
      (doorbell_pending[0] && doorbell_irq_enable[0]) |->
      general_doorbell[0])
      else $error("channel request missing");

   chan_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      !doorbell_irq_enable[1] |-> !general_doorbell[1])
      else $error("channel request while disabled");

   irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
      doorbell_irq == |(doorbell_pending & doorbell_irq_enable))
      else $error("interrupt level mismatch");

   ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(doorbell_pending[3]) |-> doorbell_request_clear[3])
      else $error("remote request not cleared");

   reset_clear_a: assert property (@(posedge clk)
      $rose(rst_b) |-> doorbell_pending == 4'h0)
      else $error("pending not clear after reset");

   ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      (wr_go && sel_control && lane3) |=>
      doorbell_irq_enable == $past(wr_hi))
      else $error("enable write not stored");

   // Request view must track the synchronised level, not the raw pin
   req_view_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_go && sel_control) |=>
      avs_readdata[MDBP_REQ_LSB +: CHANNELS] == $past(req_level))
      else $error("request view differs from remote level");

   // Only the pending field may show in a status read
   status_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rd_go && sel_status) |=> avs_readdata[27:0] == 28'h000_0000)
      else $error("status read shows bits outside pending field");

   // A lost doorbell must leave a sticky event behind
   overrun_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      evt_overrun[0] |=> evt_status[0])
      else $error("overrun event not recorded");
endmodule
`default_nettype wire

/* File: sim/mdbp_remote_model.sv */
// Remote processor model that owns the four request bits.
// Assumes it shares the clock and reset of the doorbell block.
`timescale 1ns/1ns
`default_nettype none
module mdbp_remote_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] raise,
   input wire logic rude,
   input wire logic [3:0] req_clear,
   output logic [3:0] req
);
   // Polite mode raises a bit only once it reads zero; rude mode
   // toggles bits regardless, which is the only way to force an overrun
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req <= 4'h0;
      end else if (rude) begin
         req <= req ^ raise;
      end else begin
         req <= (req & ~req_clear) | (raise & ~req);
      end
   end
endmodule
`default_nettype wire

/* File: sim/mdbp_doorbell_tb_top.sv */
// Bench for the doorbell block: bus tasks, remote model and checks.
// Assumes a register slave that stalls each access with waitrequest.
`timescale 1ns/1ns
`default_nettype none
module mdbp_doorbell_tb_top;
   import mdbp_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf; // Full words except in the top-lane test
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [3:0] req, req_clear, gen_db;
   logic [3:0] raise = 4'h0; // Commands to the remote model
   logic rude = 1'b0;
   logic doorbell_irq, event_irq;
   logic [31:0] q; // Last read data
   int miscompares = 0;
   int n_tests = 0;
   int ch;
   logic [3:0] en, one;

   // 25 MHz clock
   always #20 clk = ~clk;

   mdbp_doorbell i_mdbp_doorbell (.clk(clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .doorbell_request(req),
      .doorbell_request_clear(req_clear), .general_doorbell(gen_db),
      .doorbell_irq(doorbell_irq), .event_irq(event_irq));
   mdbp_remote_model i_mdbp_remote_model (.clk(clk), .rst_b(rst_b),
      .raise(raise), .rude(rude), .req_clear(req_clear), .req(req));

   // Expected register words
   function automatic logic [31:0] st_word(input logic [3:0] p);
      return {p, 28'h0};
   endfunction
   function automatic logic [31:0] ct_word(input logic [3:0] e, r);
      return {e, 8'h0, r, 16'h0};
   endfunction

   // One bus access; the request stands until waitrequest is seen low
   // at a rising edge, where a write lands and read data are taken
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      avs_read <= ~w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic chk_word(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [3:0] got, exp);
      chk_word({28'h0, got}, {28'h0, exp});
   endtask

   // Pulse a raise command, then let n cycles pass
   task automatic poke(input logic [3:0] m, input int n);
      raise <= m;
      @(posedge clk);
      raise <= 4'h0;
      repeat (n) @(posedge clk);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      ch = $urandom(75);
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, MDBP_OFS_STATUS, 32'h0);
      chk_word(q, st_word(4'h0));
      bus(1'b0, MDBP_OFS_CONTROL, 32'h0);
      chk_word(q, ct_word(4'h0, 4'h0));
      bus(1'b0, 8'h40, 32'hffff_ffff);
      chk_word(q, MDBP_UNMAPPED_DATA);
      // A write without the top lane must leave the enables alone
      avs_byteenable <= 4'h7;
      bus(1'b1, MDBP_OFS_CONTROL, ct_word(4'hf, 4'h0));
      avs_byteenable <= 4'hf;
      bus(1'b0, MDBP_OFS_CONTROL, 32'h0);
      chk_word(q, ct_word(4'h0, 4'h0));
      $display("test reset done");
      // Every channel once, then random ones; request view written as
      // ones to show it is read-only
      for (int i = 0; i < 8; i++) begin
         en = 4'($urandom);
         ch = (i < 4) ? i : int'($urandom % 4);
         one = 4'h1 << ch;
         bus(1'b1, MDBP_OFS_CONTROL, ct_word(en, 4'hf));
         poke(one, 8);
         bus(1'b0, MDBP_OFS_STATUS, 32'h0);
         chk_word(q, st_word(one));
         chk_pin(gen_db, en & one);
         chk_pin({3'h0, doorbell_irq}, {3'h0, |(en & one)});
         bus(1'b0, MDBP_OFS_CONTROL, 32'h0);
         chk_word(q, ct_word(en, one));
         bus(1'b1, MDBP_OFS_STATUS, st_word(~one));
         bus(1'b0, MDBP_OFS_STATUS, 32'h0);
         chk_word(q, st_word(one));
         bus(1'b1, MDBP_OFS_STATUS, st_word(one));
         repeat (8) @(posedge clk);
         chk_pin(req, 4'h0);
         chk_pin({3'h0, doorbell_irq}, 4'h0);
         bus(1'b0, MDBP_OFS_STATUS, 32'h0);
         chk_word(q, st_word(4'h0));
         chk_pin(gen_db, 4'h0);
         bus(1'b1, MDBP_OFS_STATUS, st_word(one));
         bus(1'b0, MDBP_OFS_STATUS, 32'h0);
         chk_word(q, st_word(4'h0));
      end
      $display("test channels done");
      // Overrun: a fresh rise while channel 0 is still pending
      bus(1'b1, MDBP_OFS_EVT_ENABLE, 32'h1000_0000);
      bus(1'b1, MDBP_OFS_CONTROL, 32'h0);
      poke(4'h1, 8);
      rude <= 1'b1;
      poke(4'h1, 8);
      poke(4'h1, 8);
      rude <= 1'b0;
      chk_pin({3'h0, event_irq}, 4'h1);
      bus(1'b0, MDBP_OFS_EVT_STATUS, 32'h0);
      chk_word(q, 32'h1000_0000);
      bus(1'b1, MDBP_OFS_EVT_ENABLE, 32'h0);
      repeat (2) @(negedge clk);
      chk_pin({3'h0, event_irq}, 4'h0);
      bus(1'b1, MDBP_OFS_EVT_CLEAR, 32'h1000_0000);
      bus(1'b0, MDBP_OFS_EVT_STATUS, 32'h0);
      chk_word(q, 32'h0);
      // Enabling a channel that is already pending raises its request
      bus(1'b1, MDBP_OFS_CONTROL, ct_word(4'h1, 4'h0));
      @(posedge clk);
      chk_pin(gen_db, 4'h1);
      chk_pin({3'h0, doorbell_irq}, 4'h1);
      bus(1'b1, MDBP_OFS_STATUS, st_word(4'h1));
      bus(1'b0, MDBP_OFS_STATUS, 32'h0);
      chk_word(q, st_word(4'h0));
      chk_pin(gen_db, 4'h0);
      chk_pin({3'h0, doorbell_irq}, 4'h0);
      $display("test overrun done");
      end_of_test();
   end

   // Watchdog, well beyond the roughly 430 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
